// *** design/twc_pkg.sv ***
// package for the timer waveform control register slice
package twc_pkg;
  // ************************************************************
  // register indices; byte address is four times the index
  // ************************************************************
  localparam logic [7:0] TWC_IDX_CLK_EN  = 8'h00;
  localparam logic [7:0] TWC_IDX_WAVE    = 8'h01;
  localparam logic [7:0] TWC_IDX_IDLE    = 8'h02;
  localparam logic [7:0] TWC_IDX_SPLIT   = 8'h03;
  localparam logic [7:0] TWC_IDX_CMD_CLR = 8'h04;
  localparam logic [7:0] TWC_IDX_CMD_SET = 8'h05;
  // own registers: buffer access and counter view
  localparam logic [7:0] TWC_IDX_PER_BUF = 8'h10;
  localparam logic [7:0] TWC_IDX_CMP_BUF = 8'h11;
  localparam logic [7:0] TWC_IDX_COUNT   = 8'h12;
  localparam logic [7:0] TWC_IDX_BVALID  = 8'h13;
  // ************************************************************
  // field positions and reset values
  // ************************************************************
  localparam int TWC_ENABLE_BIT   = 0;
  localparam int TWC_PSEL_LSB     = 1;
  localparam int TWC_AUTOLOCK_BIT = 3;
  localparam int TWC_OVR_LSB      = 4;
  localparam int TWC_DIR_BIT      = 0;
  localparam int TWC_LOCK_UPDATE_BIT     = 1;
  localparam int TWC_CMD_LSB      = 2;
  localparam logic [7:0]  TWC_REG_RESET = 8'h00;
  localparam logic [15:0] TWC_PER_RESET = 16'hFFFF;
  localparam logic [1:0]  TWC_RESP_OKAY   = 2'b00;
  localparam logic [1:0]  TWC_RESP_SLVERR = 2'b10;
  // ************************************************************
  // modes and commands
  // ************************************************************
  typedef enum logic [2:0] {
    TWC_WG_NORMAL = 3'h0, TWC_WG_FREQ = 3'h1, TWC_WG_ONE_SLOPE = 3'h3,
    TWC_WG_TWO_TOP = 3'h5, TWC_WG_TWO_BOTH = 3'h6, TWC_WG_TWO_BOTTOM = 3'h7
  } twc_waveform_mode_t;
  typedef enum logic [1:0] {
    TWC_CMD_NONE = 2'h0, TWC_CMD_UPDATE = 2'h1, TWC_CMD_RESTART = 2'h2, TWC_CMD_HARD = 2'h3
  } twc_cmd_t;
  // waveform output group
  typedef struct packed {
    logic [2:0] level;
    logic [2:0] override;
  } twc_wave_t;
endpackage

// *** design/twc_timer_waveform_control_regs.sv ***
// timer waveform control registers with prescaler, counter and wave outputs
// Function
// RULE_01: prescale select codes 0..7 divide clock by 1,2,4,8,16,64,256,1024.
// RULE_02: enable bit 0 starts and stops the timer.
// RULE_03: pin override bits 4..6 act only in frequency or pwm modes.
// RULE_04: auto lock holds lock update until all enabled buffers valid.
// RULE_05: cleared lock update stays zero until update, then sets again.
// RULE_06: without auto lock, hardware never alters lock update.
// RULE_07: mode 000 top period, mode 001 top compare zero; update at top.
// RULE_08: mode 011 single slope, update and overflow at bottom; code updates at top.
// RULE_09: modes 101,110,111 dual slope; overflow top, both, bottom.
// RULE_10: normal mode drives no waveform output.
// RULE_11: waveform reaches pin only with its override bit set.
// RULE_12: idle value bits set wave outputs while timer disabled; code loads them only on an idle write while disabled, not on stop.
// RULE_13: split enable bit selects two 8-bit timers and split map; code only drives split_enable, counter stays 16-bit.
// RULE_14: writing one on clear view clears that status bit.
// RULE_15: writing one on set view sets that status bit.
// RULE_16: both views read the same lock update and direction bits.
// RULE_17: command field acts on write, reads zero: update, restart, reset.
// RULE_18: hard reset command ignored while timer enabled.
// RULE_19: lock update one blocks buffer transfers.
// RULE_20: lock update zero transfers buffers on each update.
// RULE_21: direction zero counts up, one counts down.
// RULE_22: buffer valid set on buffer write, cleared on update.
// RULE_23: dual slope turns down at top and up at bottom.
// RULE_24: restart zeroes counter and direction, keeps configuration.
`timescale 1ns/1ps
module twc_timer_waveform_control_regs #(
  parameter int CHANNELS = 3
) (
  // clock and reset
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // axi4-lite write
  input  wire logic [9:0]             s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  // axi4-lite read
  input  wire logic [9:0]             s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready,
  // waveform outputs to port logic
  output twc_pkg::twc_wave_t          wave_out,
  output logic                        split_enable,
  output logic                        overflow_flag
);
  import twc_pkg::*;

  // ************************************************************
  // register state
  // ************************************************************
  logic [7:0]  clk_en_reg, clk_en_next, wave_reg, wave_next, idle_reg, idle_next;
  logic        split_reg, split_next, lock_update_reg, lock_update_next, dir_reg, dir_next;
  logic [15:0] per_reg, per_next, perbuf_reg, perbuf_next, cnt_reg, cnt_next;
  logic [15:0] cmp_reg [CHANNELS];
  logic [15:0] cmp_next [CHANNELS];
  logic [15:0] cmpbuf_reg [CHANNELS];
  logic [15:0] cmpbuf_next [CHANNELS];
  logic [CHANNELS:0] bv_reg, bv_next; // bit 0 period, then channels
  logic [2:0]  lvl_reg, lvl_next;
  logic [9:0]  pre_reg, pre_next;
  logic        ovf_reg, ovf_next;
  // bus state
  logic        aw_reg, aw_next, w_reg, w_next, bvalid_reg, bvalid_next;
  logic        rvalid_reg, rvalid_next;
  logic [9:0]  awaddr_reg, awaddr_next;
  logic [31:0] wdata_reg, wdata_next, rdata_reg, rdata_next;
  logic [3:0]  wstrb_reg, wstrb_next;
  logic [1:0]  bresp_reg, bresp_next, rresp_reg, rresp_next;

  // ************************************************************
  // decoded configuration
  // ************************************************************
  logic        enabled, autolock, tick, do_write, wave_mode, dual, at_top, at_bot;
  logic        upd_cond, transfer;
  logic [2:0]  mode, ovr;
  logic [2:0]  psel;
  logic [9:0]  pre_max;
  logic [15:0] top_val;
  logic [7:0]  widx, b0;
  twc_cmd_t    cmd;
  logic [CHANNELS-1:0] ch_en;

  assign enabled  = clk_en_reg[TWC_ENABLE_BIT];
  assign psel     = clk_en_reg[TWC_PSEL_LSB +: 3];
  assign mode     = wave_reg[2:0];
  assign autolock = wave_reg[TWC_AUTOLOCK_BIT];
  assign ovr      = wave_reg[TWC_OVR_LSB +: 3];
  assign ch_en    = ovr[CHANNELS-1:0];
  // RULE_03 override gating
  assign wave_mode = (mode != TWC_WG_NORMAL) && (mode != 3'h2) && (mode != 3'h4);
  assign dual     = mode[2] && (mode != 3'h4);
  // RULE_07 top selection
  assign top_val  = (mode == TWC_WG_FREQ) ? cmp_reg[0] : per_reg;
  assign at_top   = (cnt_reg == top_val);
  assign at_bot   = (cnt_reg == 16'h0000);
  assign do_write = aw_reg && w_reg && !bvalid_reg;
  assign widx     = awaddr_reg[9:2];
  assign b0       = wstrb_reg[0] ? wdata_reg[7:0] : 8'h00;
  assign cmd      = twc_cmd_t'(b0[TWC_CMD_LSB +: 2]);

  // RULE_01 prescale divider limits
  always_comb begin
    unique case (psel)
      3'h0:    pre_max = 10'd0;
      3'h1:    pre_max = 10'd1;
      3'h2:    pre_max = 10'd3;
      3'h3:    pre_max = 10'd7;
      3'h4:    pre_max = 10'd15;
      3'h5:    pre_max = 10'd63;
      3'h6:    pre_max = 10'd255;
      default: pre_max = 10'd1023;
    endcase
  end
  // RULE_02 count only when enabled
  assign tick = enabled && (pre_reg >= pre_max);

  // update point per mode, or forced by command
  always_comb begin
    upd_cond = 1'b0;
    if (tick) begin
      // RULE_08 bottom update for dual slope modes, single slope at top
      if (mode == TWC_WG_NORMAL || mode == TWC_WG_FREQ) upd_cond = at_top;
      else upd_cond = dual ? (at_bot && dir_reg) : at_top;
    end
    if (do_write && wstrb_reg[0] && cmd == TWC_CMD_UPDATE &&
        (widx == TWC_IDX_CMD_CLR || widx == TWC_IDX_CMD_SET)) upd_cond = 1'b1;
  end
  // RULE_19 RULE_20 lock gates transfer
  assign transfer = upd_cond && !lock_update_reg;

  // ************************************************************
  // timer and register next state
  // ************************************************************
  always_comb begin
    clk_en_next = clk_en_reg; wave_next = wave_reg; idle_next = idle_reg;
    split_next = split_reg; lock_update_next = lock_update_reg; dir_next = dir_reg;
    per_next = per_reg; perbuf_next = perbuf_reg; cnt_next = cnt_reg;
    bv_next = bv_reg; lvl_next = lvl_reg; ovf_next = 1'b0;
    for (int i = 0; i < CHANNELS; i++) begin
      cmp_next[i] = cmp_reg[i];
      cmpbuf_next[i] = cmpbuf_reg[i];
    end
    pre_next = (enabled && !tick) ? pre_reg + 10'd1 : 10'd0;
    // RULE_21 counting direction
    if (tick) begin
      if (mode == TWC_WG_ONE_SLOPE || mode == TWC_WG_NORMAL || mode == TWC_WG_FREQ) begin
        if (!dir_reg) cnt_next = at_top ? 16'h0000 : cnt_reg + 16'h0001;
        else cnt_next = at_bot ? top_val : cnt_reg - 16'h0001;
        ovf_next = (mode == TWC_WG_ONE_SLOPE) ? at_bot : at_top;
      end else if (dual) begin
        // RULE_23 turn around at the ends
        if (at_top && !dir_reg) begin
          dir_next = 1'b1; cnt_next = cnt_reg - 16'h0001;
        end else if (at_bot && dir_reg) begin
          dir_next = 1'b0; cnt_next = cnt_reg + 16'h0001;
        end else cnt_next = dir_reg ? cnt_reg - 16'h0001 : cnt_reg + 16'h0001;
        // RULE_09 overflow point per dual mode
        unique case (mode)
          TWC_WG_TWO_TOP:  ovf_next = at_top && !dir_reg;
          TWC_WG_TWO_BOTH: ovf_next = (at_top && !dir_reg) || (at_bot && dir_reg);
          default:         ovf_next = at_bot && dir_reg;
        endcase
      end
      // waveform generator: compare match sets level state
      for (int i = 0; i < CHANNELS; i++)
        if (mode == TWC_WG_FREQ) lvl_next[i] = at_top ? ~lvl_reg[i] : lvl_reg[i];
        else lvl_next[i] = (cnt_next < cmp_reg[i]);
    end
    // RULE_22 RULE_20 buffer transfer clears valid flags
    if (transfer) begin
      if (bv_reg[0]) per_next = perbuf_reg;
      for (int i = 0; i < CHANNELS; i++) if (bv_reg[i+1]) cmp_next[i] = cmpbuf_reg[i];
      bv_next = '0;
    end
    // RULE_04 auto lock clears once enabled buffers valid
    if (autolock && lock_update_reg && ((bv_reg[CHANNELS:1] & ch_en) == ch_en)) lock_update_next = 1'b0;
    if (do_write && wstrb_reg[0]) begin
      unique case (widx)
        TWC_IDX_CLK_EN: clk_en_next = {4'h0, b0[3:0]};
        TWC_IDX_WAVE:   wave_next = {1'b0, b0[6:0]};
        // RULE_12 idle value only while stopped
        TWC_IDX_IDLE: begin
          idle_next = {5'h00, b0[2:0]};
          if (!enabled) lvl_next = b0[2:0];
        end
        // RULE_13 split select
        TWC_IDX_SPLIT: split_next = b0[0];
        // RULE_14 clear view
        TWC_IDX_CMD_CLR: begin
          if (b0[TWC_LOCK_UPDATE_BIT]) lock_update_next = 1'b0;
          if (b0[TWC_DIR_BIT]) dir_next = 1'b0;
        end
        // RULE_15 set view
        TWC_IDX_CMD_SET: begin
          if (b0[TWC_LOCK_UPDATE_BIT]) lock_update_next = 1'b1;
          if (b0[TWC_DIR_BIT]) dir_next = 1'b1;
        end
        TWC_IDX_PER_BUF: begin
          perbuf_next = wdata_reg[15:0]; bv_next[0] = 1'b1;
        end
        TWC_IDX_CMP_BUF: begin
          for (int i = 0; i < CHANNELS; i++)
            if (wdata_reg[17:16] == i[1:0]) begin
              cmpbuf_next[i] = wdata_reg[15:0]; bv_next[i+1] = 1'b1;
            end
        end
        default: ;
      endcase
      // RULE_17 RULE_24 restart keeps configuration
      if ((widx == TWC_IDX_CMD_CLR || widx == TWC_IDX_CMD_SET)) begin
        if (cmd == TWC_CMD_RESTART) begin
          cnt_next = 16'h0000; dir_next = 1'b0; pre_next = 10'd0;
        end
        // RULE_18 hard reset only while stopped
        if (cmd == TWC_CMD_HARD && !enabled) begin
          cnt_next = 16'h0000; dir_next = 1'b0; lock_update_next = 1'b0; bv_next = '0;
          per_next = TWC_PER_RESET; lvl_next = 3'h0;
          for (int i = 0; i < CHANNELS; i++) begin
            cmp_next[i] = 16'h0000; cmpbuf_next[i] = 16'h0000;
          end
        end
      end
    end
    // RULE_05 set at update; placed after writes so the hardware set wins
    if (autolock && upd_cond && !lock_update_reg) lock_update_next = 1'b1;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      clk_en_reg <= TWC_REG_RESET; wave_reg <= TWC_REG_RESET; idle_reg <= TWC_REG_RESET;
      split_reg <= 1'b0; lock_update_reg <= 1'b0; dir_reg <= 1'b0; per_reg <= TWC_PER_RESET;
      perbuf_reg <= 16'h0000; cnt_reg <= 16'h0000; bv_reg <= '0; lvl_reg <= 3'h0;
      pre_reg <= 10'd0; ovf_reg <= 1'b0;
      for (int i = 0; i < CHANNELS; i++) begin
        cmp_reg[i] <= 16'h0000; cmpbuf_reg[i] <= 16'h0000;
      end
    end else begin
      clk_en_reg <= clk_en_next; wave_reg <= wave_next; idle_reg <= idle_next;
      split_reg <= split_next; lock_update_reg <= lock_update_next; dir_reg <= dir_next;
      per_reg <= per_next; perbuf_reg <= perbuf_next; cnt_reg <= cnt_next;
      bv_reg <= bv_next; lvl_reg <= lvl_next; pre_reg <= pre_next; ovf_reg <= ovf_next;
      for (int i = 0; i < CHANNELS; i++) begin
        cmp_reg[i] <= cmp_next[i]; cmpbuf_reg[i] <= cmpbuf_next[i];
      end
    end
  end

  // ************************************************************
  // axi4-lite slave, one write and one read at a time
  // ************************************************************
  always_comb begin
    aw_next = aw_reg; w_next = w_reg; awaddr_next = awaddr_reg; wdata_next = wdata_reg;
    wstrb_next = wstrb_reg; bvalid_next = bvalid_reg; bresp_next = bresp_reg;
    rvalid_next = rvalid_reg; rdata_next = rdata_reg; rresp_next = rresp_reg;
    if (s_axi_awvalid && !aw_reg) begin
      aw_next = 1'b1; awaddr_next = s_axi_awaddr;
    end
    if (s_axi_wvalid && !w_reg) begin
      w_next = 1'b1; wdata_next = s_axi_wdata; wstrb_next = s_axi_wstrb;
    end
    if (do_write) begin
      bvalid_next = 1'b1;
      bresp_next = (widx <= TWC_IDX_CMD_SET || (widx >= TWC_IDX_PER_BUF &&
                    widx <= TWC_IDX_BVALID)) ? TWC_RESP_OKAY : TWC_RESP_SLVERR;
    end
    if (bvalid_reg && s_axi_bready) begin
      bvalid_next = 1'b0; aw_next = 1'b0; w_next = 1'b0;
    end
    if (rvalid_reg && s_axi_rready) rvalid_next = 1'b0;
    if (s_axi_arvalid && !rvalid_reg) begin
      rvalid_next = 1'b1; rresp_next = TWC_RESP_OKAY; rdata_next = 32'h0000_0000;
      unique case (s_axi_araddr[9:2])
        TWC_IDX_CLK_EN: rdata_next[7:0] = clk_en_reg;
        TWC_IDX_WAVE:   rdata_next[7:0] = wave_reg;
        TWC_IDX_IDLE:   rdata_next[7:0] = idle_reg;
        TWC_IDX_SPLIT:  rdata_next[0] = split_reg;
        // RULE_16 same status on both views, command reads zero
        TWC_IDX_CMD_CLR, TWC_IDX_CMD_SET: rdata_next[1:0] = {lock_update_reg, dir_reg};
        TWC_IDX_PER_BUF: rdata_next[15:0] = perbuf_reg;
        TWC_IDX_CMP_BUF: rdata_next[15:0] = cmp_reg[0];
        TWC_IDX_COUNT:   rdata_next[15:0] = cnt_reg;
        TWC_IDX_BVALID:  rdata_next[CHANNELS:0] = bv_reg;
        default:         rresp_next = TWC_RESP_SLVERR;
      endcase
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_reg <= 1'b0; w_reg <= 1'b0; awaddr_reg <= 10'h000; wdata_reg <= 32'h0000_0000;
      wstrb_reg <= 4'h0; bvalid_reg <= 1'b0; bresp_reg <= TWC_RESP_OKAY;
      rvalid_reg <= 1'b0; rdata_reg <= 32'h0000_0000; rresp_reg <= TWC_RESP_OKAY;
    end else begin
      aw_reg <= aw_next; w_reg <= w_next; awaddr_reg <= awaddr_next; wdata_reg <= wdata_next;
      wstrb_reg <= wstrb_next; bvalid_reg <= bvalid_next; bresp_reg <= bresp_next;
      rvalid_reg <= rvalid_next; rdata_reg <= rdata_next; rresp_reg <= rresp_next;
    end
  end

  // ready pulses only mark capture; held low while a word is pending
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0; s_axi_wready <= 1'b0; s_axi_arready <= 1'b0;
    end else begin
      s_axi_awready <= s_axi_awvalid && !aw_reg && !s_axi_awready;
      s_axi_wready  <= s_axi_wvalid && !w_reg && !s_axi_wready;
      s_axi_arready <= s_axi_arvalid && !rvalid_reg && !s_axi_arready;
    end
  end
  assign s_axi_bvalid = bvalid_reg;
  assign s_axi_bresp  = bresp_reg;
  assign s_axi_rvalid = rvalid_reg;
  assign s_axi_rdata  = rdata_reg;
  assign s_axi_rresp  = rresp_reg;
  // RULE_10 RULE_11 pins driven only with override in waveform modes
  assign wave_out.level    = lvl_reg;
  assign wave_out.override = wave_mode ? ovr : 3'h0;
  assign split_enable  = split_reg;
  assign overflow_flag = ovf_reg;

  // ************************************************************
  // assertions
  // ************************************************************
  property p_no_override_normal; // RULE_10
    @(posedge aclk) disable iff (!aresetn) (mode == TWC_WG_NORMAL) |-> wave_out.override == 3'h0;
  endproperty
  a_no_override_normal: assert property (p_no_override_normal) else $error("override in normal"); // RULE_10
  property p_lock_blocks; // RULE_19
    @(posedge aclk) disable iff (!aresetn) (lock_update_reg && !do_write) |=> $stable(per_reg);
  endproperty
  a_lock_blocks: assert property (p_lock_blocks) else $error("update while locked"); // RULE_19
  property p_no_auto_lock_update; // RULE_06
    @(posedge aclk) disable iff (!aresetn) (!autolock && !do_write) |=> $stable(lock_update_reg);
  endproperty
  a_no_auto_lock_update: assert property (p_no_auto_lock_update) else $error("lock changed by hardware"); // RULE_06
  property p_stop_no_count; // RULE_02
    @(posedge aclk) disable iff (!aresetn) (!enabled && !do_write) |=> $stable(cnt_reg);
  endproperty
  a_stop_no_count: assert property (p_stop_no_count) else $error("counted while stopped"); // RULE_02
  property p_hard_ignored; // RULE_18
    @(posedge aclk) disable iff (!aresetn) (do_write && enabled && cmd == TWC_CMD_HARD &&
      widx == TWC_IDX_CMD_SET && wstrb_reg[0]) |=> per_reg == $past(per_reg) || $past(transfer);
  endproperty
  a_hard_ignored: assert property (p_hard_ignored) else $error("hard reset while enabled"); // RULE_18
  property p_transfer_clears_bv; // RULE_22
    @(posedge aclk) disable iff (!aresetn) (transfer && !do_write) |=> bv_reg == '0;
  endproperty
  a_transfer_clears_bv: assert property (p_transfer_clears_bv) else $error("valid kept"); // RULE_22
  property p_div1_ticks; // RULE_01
    @(posedge aclk) disable iff (!aresetn) (enabled && psel == 3'h0) |-> tick;
  endproperty
  a_div1_ticks: assert property (p_div1_ticks) else $error("no tick at div1"); // RULE_01
  property p_cmd_reads_zero; // RULE_17
    @(posedge aclk) disable iff (!aresetn)
      (s_axi_arvalid && !rvalid_reg && s_axi_araddr[9:2] == TWC_IDX_CMD_SET) |=> rdata_reg[3:2] == 2'b00;
  endproperty
  a_cmd_reads_zero: assert property (p_cmd_reads_zero) else $error("command read nonzero"); // RULE_17
endmodule

// *** verification/twc_pin_model.sv ***
// port pin model that receives the timer waveform outputs
`timescale 1ns/1ps
module twc_pin_model (
  // waveform group from the timer
  input  wire twc_pkg::twc_wave_t wave_out,
  // port register settings
  input  wire logic [2:0]         port_out,
  input  wire logic [2:0]         pin_dir,
  // pad levels
  output logic [2:0]              pin_level
);
  import twc_pkg::*;
  // override needs output
  // an input pin rests at its pull-up, so a stale level never shows through
  always_comb begin
    for (int i = 0; i < 3; i++) begin
      pin_level[i] = 1'b1;
      if (pin_dir[i]) pin_level[i] = wave_out.override[i] ? wave_out.level[i] : port_out[i];
    end
  end
endmodule

// *** verification/tb_top.sv ***
// self-checking testbench for the timer waveform control registers
`timescale 1ns/1ps
module tb_top;
  import twc_pkg::*;
  typedef struct {logic [7:0] idx; logic [7:0] wr; logic [7:0] rd;} twc_row_t;
  logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, split_en, ovf;
  logic [9:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rd, ovf_cnt, base;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [2:0]  port_out, pin_dir, pin_level;
  twc_wave_t   wave;
  int          fail_count, num_checks;
  twc_row_t    rows [8] = '{'{TWC_IDX_CLK_EN, 8'h0E, 8'h0E}, '{TWC_IDX_WAVE, 8'h73, 8'h73},
    '{TWC_IDX_IDLE, 8'h01, 8'h01}, '{TWC_IDX_SPLIT, 8'h01, 8'h01},
    '{TWC_IDX_CMD_SET, 8'h03, 8'h03}, '{TWC_IDX_CMD_CLR, 8'h01, 8'h02},
    '{TWC_IDX_CMD_SET, 8'h04, 8'h02}, '{TWC_IDX_CMD_CLR, 8'h00, 8'h02}};

  twc_timer_waveform_control_regs twc_timer_waveform_control_regs_i (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .wave_out(wave), .split_enable(split_en), .overflow_flag(ovf));
  twc_pin_model twc_pin_model_i (.wave_out(wave), .port_out(port_out), .pin_dir(pin_dir),
    .pin_level(pin_level));

  // ************************************************************
  // clock, overflow tally and shared tasks
  // ************************************************************
  initial begin
    aclk = 1'b0;
    forever #50 aclk = ~aclk;
  end
  // overflow pulses stand one cycle, so each edge is looked at
  always @(posedge aclk) if (ovf === 1'b1) ovf_cnt <= ovf_cnt + 32'h1;

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask
  // write: address and data offered together, each dropped once taken
  task automatic axw(input logic [7:0] idx, input logic [7:0] d);
    @(posedge aclk);
    awaddr <= {idx, 2'b00};
    wdata <= {24'h000000, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask
  task automatic axr(input logic [7:0] idx);
    @(posedge aclk);
    araddr <= {idx, 2'b00};
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask
  task automatic results();
    $display("checks %0d, mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  // watchdog: the whole sequence needs well under 3000 cycles
  initial begin
    #2000000;
    fail_count++;
    results();
  end

  // ************************************************************
  // main sequence
  // ************************************************************
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, ovf_cnt} = '0;
    wstrb = 4'h1;
    port_out = 3'b111;
    pin_dir = 3'b101;
    repeat (8) @(posedge aclk);
    aresetn <= 1'b1;
    // register reset values
    for (int i = 0; i < 6; i++) begin
      axr(8'(i));
      check(rd, 32'h0);
    end
    for (int i = 0; i < 8; i++) begin
      axw(rows[i].idx, rows[i].wr);
      axr(rows[i].idx);
      check(rd, {24'h000000, rows[i].rd}); // views
    end
    check({31'h0, split_en}, 32'h1); // split output
    check({29'h0, wave.override}, 32'h7); // pwm override
    check({29'h0, wave.level}, 32'h1); // idle level
    check({29'h0, pin_level}, 32'h3); // pin levels
    axw(TWC_IDX_IDLE, 8'h06);
    repeat (2) @(posedge aclk);
    check({29'h0, wave.level}, 32'h6); // new idle level
    axw(TWC_IDX_WAVE, 8'h70);
    port_out <= 3'b000;
    repeat (2) @(posedge aclk);
    check({29'h0, wave.override}, 32'h0); // normal mode
    check({29'h0, pin_level}, 32'h2); // port respected
    // unmapped place is refused
    axr(8'hFF);
    check({rd[29:0], resp}, {30'h0, TWC_RESP_SLVERR});
    axw(8'hFF, 8'h5A);
    check({30'h0, resp}, {30'h0, TWC_RESP_SLVERR});
    // period 9 gives one overflow per ten timer ticks
    axw(TWC_IDX_CMD_CLR, 8'h02);
    axw(TWC_IDX_PER_BUF, 8'h09);
    axw(TWC_IDX_CMD_SET, 8'h04);
    axw(TWC_IDX_CLK_EN, 8'h01);
    base = ovf_cnt;
    repeat (200) @(posedge aclk);
    check({31'h0, (ovf_cnt - base) inside {[19:21]}}, 32'h1); // top rate
    axw(TWC_IDX_CLK_EN, 8'h05);
    base = ovf_cnt;
    repeat (200) @(posedge aclk);
    check({31'h0, (ovf_cnt - base) inside {[4:6]}}, 32'h1); // divide by four
    axw(TWC_IDX_CMD_SET, 8'h0C);
    axr(TWC_IDX_CLK_EN);
    check(rd, 32'h5); // clock register kept after hard reset
    axw(TWC_IDX_CLK_EN, 8'h00);
    axw(TWC_IDX_CMD_SET, 8'h08);
    axr(TWC_IDX_COUNT);
    check(rd, 32'h0); // restart zeroes counter
    // auto lock on channel 0, updates forced while stopped so nothing races
    axw(TWC_IDX_WAVE, 8'h18);
    axw(TWC_IDX_CMD_SET, 8'h04);
    axr(TWC_IDX_CMD_SET);
    check(rd, 32'h2); // lock set at update
    axw(TWC_IDX_CMP_BUF, 8'h2A);
    axr(TWC_IDX_CMD_SET);
    check(rd, 32'h0); // lock cleared when buffers valid
    axw(TWC_IDX_CMD_SET, 8'h04);
    axr(TWC_IDX_CMP_BUF);
    check(rd, 32'h2A); // buffer copied
    axr(TWC_IDX_BVALID);
    check(rd, 32'h0); // valid flags cleared
    axr(TWC_IDX_CMD_SET);
    check(rd, 32'h2); // lock set again
    results();
  end
endmodule
